// [hdl/dpou_regs.svh]
// constants of the parallel dsp operation unit: field positions, codes, reset values
// assumes inclusion by the package and the top module only
`ifndef DPOU_REGS_SVH
`define DPOU_REGS_SVH
`define DPOU_PREFIX_HI    31
`define DPOU_PREFIX_LO    26
`define DPOU_PREFIX_CODE  6'h3E
`define DPOU_ACC_RESET    40'h00_0000_0000
`define DPOU_REG_RESET    32'h0000_0000
`define DPOU_ROUND_CONST  40'h00_0000_8000
`define DPOU_CS_CARRY     3'h0
`define DPOU_CS_NEG       3'h1
`define DPOU_CS_ZERO      3'h2
`define DPOU_CS_OVF       3'h3
`define DPOU_CS_SGT       3'h4
`define DPOU_CS_SGE       3'h5
`endif

// [hdl/dpou_pkg.sv]
// types of the parallel dsp operation unit
// assumes the constants header is available on the include path
package dpou_pkg;
  `include "dpou_regs.svh"
  typedef logic [39:0] dpou_word_type;
  // register numbering used on the dest_single selector and by the read-out ports
  typedef enum logic [2:0] {
    DPOU_ACC_ZERO, DPOU_ACC_ONE, DPOU_MUL_OUT_ZERO, DPOU_MUL_OUT_ONE,
    DPOU_XIN_ZERO, DPOU_XIN_ONE, DPOU_YIN_ZERO, DPOU_YIN_ONE
  } dpou_reg_type;
  typedef enum logic [1:0] {
    DPOU_KIND_DUAL, DPOU_KIND_COND, DPOU_KIND_UNCOND, DPOU_KIND_NONE
  } dpou_kind_type;
  typedef enum logic [3:0] {
    DPOU_OP_NOP, DPOU_OP_ADD, DPOU_OP_SUB, DPOU_OP_ASH, DPOU_OP_LSH, DPOU_OP_COPY,
    DPOU_OP_NORM, DPOU_OP_INC, DPOU_OP_NEG, DPOU_OP_OR, DPOU_OP_AND, DPOU_OP_XOR,
    DPOU_OP_DEC, DPOU_OP_CLR
  } dpou_op_type;
endpackage

// [hdl/dpou_top.sv]
// parallel dsp operation unit: decodes the b field of a 32-bit parallel word and
// executes it on the eight dsp registers, updating cond_flag.
// assumes the issue stage presents one word per cycle with valid; the a field is
// passed out for the double-transfer logic, which writes loaded values back.
`timescale 1ns/1ns
`include "dpou_regs.svh"
// Functional notes
// RULE1 - one 32-bit word gives both fields
// RULE2 - a field handled as double transfer
// RULE3 - fields execute independently of each other
// RULE4 - b field is dual, conditional or unconditional
// RULE5 - operand selectors restricted to listed registers
// RULE6 - unconditional alu and shift update flag
// RULE7 - conditional and multiply leave flag alone
// RULE8 - condition-select field picks flag rule
// RULE9 - true/false prefix gates register write
// RULE10 - add and subtract codes decoded
// RULE11 - dual add/sub plus multiply together
// RULE12 - standalone signed multiply decoded
// RULE13 - arithmetic shift by signed amount
// RULE14 - logical shift by signed amount
// RULE15 - copy from either source group
// RULE16 - normalization count into destination
// RULE17 - increment upper word of source
// RULE18 - negate source into destination
// RULE19 - bitwise or, and, xor
// RULE20 - decrement upper bits of source
// RULE21 - carry mode: carry, shifted bit, cleared
// RULE22 - zero mode flags all-zero result
// RULE23 - negative mode copies result sign
// RULE24 - selector mapping held in one function (multiply sources map in mul_sel, dest_single by a cast)
module dpou_top
  import dpou_pkg::*;
(
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  // instruction issue
  input  wire logic         insn_valid_i,
  input  wire logic [31:0]  insn_i,
  input  wire logic [2:0]   cond_select_i,
  // loads from the double-transfer logic
  input  wire logic         x_load_i,
  input  wire logic         x_load_sel_i,
  input  wire logic [15:0]  x_load_data_i,
  input  wire logic         y_load_i,
  input  wire logic         y_load_sel_i,
  input  wire logic [15:0]  y_load_data_i,
  // transfer field for the double-transfer logic
  output logic              xfer_valid_o,
  output logic [15:0]       xfer_field_o,
  // state
  output logic              cond_flag_o,
  output logic [39:0]       acc_zero_o,
  output logic [39:0]       acc_one_o,
  output logic [31:0]       mul_out_zero_o,
  output logic [31:0]       mul_out_one_o,
  output logic [31:0]       xin_zero_o,
  output logic [31:0]       xin_one_o,
  output logic [31:0]       yin_zero_o,
  output logic [31:0]       yin_one_o,
  output logic              illegal_o
);

  // ==========================================================
  // reset release
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================
  // register file
  dpou_word_type rf [8];
  logic          flag;

  // selector mapping for src_a, src_b, dest_alu_pair and mul_dest lives here
  function automatic dpou_reg_type map_sel(input logic [1:0] f, input logic [1:0] grp); // RULE24
    dpou_reg_type r;
    r = DPOU_ACC_ZERO;
    case (grp)
      2'h0: case (f) // src_a
        2'h0: r = DPOU_XIN_ZERO;
        2'h1: r = DPOU_XIN_ONE;
        2'h2: r = DPOU_ACC_ZERO;
        default: r = DPOU_ACC_ONE;
      endcase
      2'h1: case (f) // src_b
        2'h0: r = DPOU_YIN_ZERO;
        2'h1: r = DPOU_YIN_ONE;
        2'h2: r = DPOU_MUL_OUT_ZERO;
        default: r = DPOU_MUL_OUT_ONE;
      endcase
      2'h2: case (f) // dest_alu_pair
        2'h0: r = DPOU_XIN_ZERO;
        2'h1: r = DPOU_YIN_ZERO;
        2'h2: r = DPOU_ACC_ZERO;
        default: r = DPOU_ACC_ONE;
      endcase
      default: case (f) // mul_dest
        2'h0: r = DPOU_MUL_OUT_ZERO;
        2'h1: r = DPOU_MUL_OUT_ONE;
        2'h2: r = DPOU_ACC_ZERO;
        default: r = DPOU_ACC_ONE;
      endcase
    endcase
    return r;
  endfunction

  function automatic dpou_reg_type mul_sel(input logic [1:0] f, input logic second);
    dpou_reg_type r;
    case (f)
      2'h0: r = second ? DPOU_YIN_ZERO : DPOU_XIN_ZERO;
      2'h1: r = second ? DPOU_YIN_ONE : DPOU_XIN_ONE;
      2'h2: r = second ? DPOU_XIN_ZERO : DPOU_YIN_ZERO;
      default: r = DPOU_ACC_ONE;
    endcase
    return r;
  endfunction

  function automatic logic is_acc(input dpou_reg_type r);
    return (r == DPOU_ACC_ZERO) || (r == DPOU_ACC_ONE);
  endfunction

  // operand read: 32-bit registers sign-extend into 40 bits
  function automatic dpou_word_type rd(input dpou_word_type v, input dpou_reg_type r);
    return is_acc(r) ? v : {{8{v[31]}}, v[31:0]};
  endfunction

  // ==========================================================
  // decode
  logic [15:0]   bf;
  logic          is_par;
  dpou_op_type   op;
  dpou_kind_type kind;
  logic          unc_ok, dual;
  logic [1:0]    cond;
  dpou_reg_type  sa, sb, dz, du, se, sf, dg;
  logic          one_src_b, logical;

  assign bf     = insn_i[15:0];                                        // RULE1
  assign is_par = insn_i[`DPOU_PREFIX_HI:`DPOU_PREFIX_LO] == `DPOU_PREFIX_CODE;
  assign sa = map_sel(bf[7:6], 2'h0);                                  // RULE5
  assign sb = map_sel(bf[5:4], 2'h1);                                  // RULE5
  assign dz = dpou_reg_type'(bf[2:0]);                                 // RULE5
  assign du = map_sel(bf[1:0], 2'h2);                                  // RULE5
  assign dg = map_sel(bf[3:2], 2'h3);                                  // RULE5
  assign se = mul_sel(bf[11:10], 1'b0);                                // RULE5
  assign sf = mul_sel(bf[9:8], 1'b1);                                  // RULE5
  assign cond = bf[9:8];
  assign one_src_b = bf[13];

  always_comb begin
    op = DPOU_OP_NOP;
    dual = 1'b0;
    unc_ok = 1'b0;
    logical = 1'b0;
    if (bf[15:13] == 3'h3 || bf[15:12] == 4'h4) begin                  // RULE4
      dual = 1'b1;
      op = (bf[15:12] == 4'h7) ? DPOU_OP_ADD : (bf[15:12] == 4'h6) ? DPOU_OP_SUB : DPOU_OP_NOP; // RULE11 RULE12
    end else if (bf[15] && cond != 2'h0) begin
      case ({bf[14:10]})
        5'h0C: op = DPOU_OP_ADD;                                       // RULE10
        5'h08: op = DPOU_OP_SUB;                                       // RULE10
        5'h04: op = DPOU_OP_ASH;                                       // RULE13
        5'h00: op = DPOU_OP_LSH;                                       // RULE14
        5'h16, 5'h1E: op = DPOU_OP_COPY;                               // RULE15
        5'h07, 5'h0F: op = DPOU_OP_NORM;                               // RULE16
        5'h06, 5'h0E: op = DPOU_OP_INC;                                // RULE17
        5'h12, 5'h1A: op = DPOU_OP_NEG;                                // RULE18
        5'h0D: op = DPOU_OP_OR;                                        // RULE19
        5'h05: op = DPOU_OP_AND;                                       // RULE19
        5'h09: op = DPOU_OP_XOR;                                       // RULE19
        5'h02, 5'h0A: op = DPOU_OP_DEC;                                // RULE20
        5'h03: op = DPOU_OP_CLR;
        default: op = DPOU_OP_NOP;
      endcase
    end
    logical = (op == DPOU_OP_LSH) || (op == DPOU_OP_OR) || (op == DPOU_OP_AND) ||
              (op == DPOU_OP_XOR);
    // the unconditional arithmetic shift has no listed code, so only flagged forms exist
    if (op == DPOU_OP_ASH && cond == 2'h1) begin
      op = DPOU_OP_NOP;
    end
    unc_ok = !dual && cond == 2'h1;
  end
  assign kind = dual ? DPOU_KIND_DUAL : (op == DPOU_OP_NOP) ? DPOU_KIND_NONE :
                unc_ok ? DPOU_KIND_UNCOND : DPOU_KIND_COND;             // RULE4

  // prefix gating
  logic do_exec;
  always_comb begin
    case (cond)
      2'h2: do_exec = flag;                                            // RULE9
      2'h3: do_exec = !flag;                                           // RULE9
      default: do_exec = 1'b1;
    endcase
  end

  // ==========================================================
  // execute
  dpou_word_type a, b, res, next_mul;
  logic          carry, shout, ovf, wr;
  logic signed [7:0] amt;
  logic [40:0]   wide;
  logic [5:0]    nc;
  dpou_word_type ma, mb;
  logic signed [31:0] prod;

  assign a  = rd(rf[sa], sa);
  assign b  = rd(rf[sb], sb);
  assign ma = rd(rf[se], se);
  assign mb = rd(rf[sf], sf);
  assign prod     = signed'(ma[31:16]) * signed'(mb[31:16]);
  assign next_mul = {8'h00, prod[30:0], 1'b0};                         // RULE11 RULE12

  always_comb begin
    dpou_word_type src;
    logic          found;
    src = one_src_b ? b : a;
    found = 1'b0;
    wide = 41'h0;
    res = 40'h0;
    carry = 1'b0;
    shout = 1'b0;
    nc = 6'h0;
    amt = signed'(b[23:16]);
    case (op)
      DPOU_OP_ADD: begin
        wide = {1'b0, a} + {1'b0, b};                                  // RULE10
        res = wide[39:0];
        carry = wide[40];
      end
      DPOU_OP_SUB: begin
        wide = {1'b0, a} - {1'b0, b};                                  // RULE10
        res = wide[39:0];
        carry = wide[40];
      end
      DPOU_OP_ASH: begin
        if (!amt[7]) begin                                             // RULE13
          res = a <<< amt[5:0];
          shout = (amt == 8'sh00) ? 1'b0 : a[6'd40 - amt[5:0]];
        end else begin
          res = 40'($signed(a) >>> (6'(-amt)));
          shout = a[6'(-amt) - 6'h1];
        end
      end
      DPOU_OP_LSH: begin
        if (!amt[7]) begin                                             // RULE14
          res = {8'h00, a[31:0] << amt[4:0]};
          shout = (amt == 8'sh00) ? 1'b0 : a[6'd32 - {1'b0, amt[4:0]}];
        end else begin
          res = {8'h00, a[31:0] >> (5'(-amt))};
          shout = a[6'({1'b0, 5'(-amt)}) - 6'h1];
        end
      end
      DPOU_OP_COPY: res = src;                                         // RULE15
      DPOU_OP_NORM: begin                                              // RULE16
        for (int i = 38; i >= 0; i--) begin
          if (!found && src[i] != src[39]) begin
            nc = 6'(38 - i);
            found = 1'b1;
          end
        end
        res = {{24{1'b0}}, 16'(nc) - 16'h0008};
      end
      DPOU_OP_INC: res = {src[39:16] + 24'h000001, 16'h0000};          // RULE17
      DPOU_OP_NEG: begin
        wide = 41'h0 - {1'b0, src};                                    // RULE18
        res = wide[39:0];
        carry = wide[40];
      end
      DPOU_OP_OR:  res = {8'h00, a[31:0] | b[31:0]};                   // RULE19
      DPOU_OP_AND: res = {8'h00, a[31:0] & b[31:0]};                   // RULE19
      DPOU_OP_XOR: res = {8'h00, a[31:0] ^ b[31:0]};                   // RULE19
      DPOU_OP_DEC: res = one_src_b ? {{8{b[31]}}, b[31:16] - 16'h0001, 16'h0000} // RULE20
                                   : {a[39:16] - 24'h000001, 16'h0000};          // RULE20
      default: res = 40'h0;
    endcase
  end

  assign ovf = res[39:31] != {9{res[31]}};
  assign wr  = insn_valid_i && is_par && kind != DPOU_KIND_NONE && (dual || do_exec); // RULE9

  // flag rule chosen by the condition-select field
  function automatic logic next_flag_of(input logic [2:0] cs, input logic lg,
                                        input logic sh, input logic cy, input logic so,
                                        input dpou_word_type r, input logic ov);
    logic neg, zero;
    neg  = lg ? r[31] : r[39];
    zero = lg ? (r[31:0] == 32'h0) : (r == 40'h0);
    case (cs)                                                          // RULE8
      `DPOU_CS_CARRY: return lg && !sh ? 1'b0 : (sh ? so : cy);         // RULE21
      `DPOU_CS_NEG:   return neg;                                      // RULE23
      `DPOU_CS_ZERO:  return zero;                                     // RULE22
      `DPOU_CS_OVF:   return lg ? 1'b0 : ov;
      `DPOU_CS_SGT:   return lg ? 1'b0 : !((r[39] ^ ov) | zero);
      `DPOU_CS_SGE:   return lg ? 1'b0 : !(r[39] ^ ov);
      default:        return 1'b0;
    endcase
  endfunction

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (wr && (kind == DPOU_KIND_UNCOND || dual) && op != DPOU_OP_NOP) begin // RULE6 RULE7
      flag <= next_flag_of(cond_select_i, logical,
                           op == DPOU_OP_ASH || op == DPOU_OP_LSH,
                           carry, shout, res, ovf);
    end
  end

  // register writes: b-field result, multiply, then transfer loads (RULE3: separate ports)
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        rf[i] <= `DPOU_ACC_RESET;
      end
    end else begin
      if (wr && op != DPOU_OP_NOP) begin
        rf[dual ? du : dz] <= res;                                     // RULE3
      end
      if (wr && dual) begin
        rf[dg] <= is_acc(dg) ? {{8{next_mul[31]}}, next_mul[31:0]} : next_mul; // RULE11 RULE12
      end
      if (x_load_i) begin
        rf[x_load_sel_i ? DPOU_XIN_ONE : DPOU_XIN_ZERO] <= {8'h00, x_load_data_i, 16'h0000}; // RULE2
      end
      if (y_load_i) begin
        rf[y_load_sel_i ? DPOU_YIN_ONE : DPOU_YIN_ZERO] <= {8'h00, y_load_data_i, 16'h0000}; // RULE2
      end
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      xfer_valid_o <= 1'b0;
      xfer_field_o <= 16'h0000;
      illegal_o    <= 1'b0;
    end else begin
      xfer_valid_o <= insn_valid_i && is_par;                          // RULE2 RULE3
      xfer_field_o <= insn_i[31:16];                                   // RULE1
      illegal_o    <= insn_valid_i && is_par && kind == DPOU_KIND_NONE && bf != 16'h0000;
    end
  end

  assign cond_flag_o    = flag;
  assign acc_zero_o     = rf[DPOU_ACC_ZERO];
  assign acc_one_o      = rf[DPOU_ACC_ONE];
  assign mul_out_zero_o = rf[DPOU_MUL_OUT_ZERO][31:0];
  assign mul_out_one_o  = rf[DPOU_MUL_OUT_ONE][31:0];
  assign xin_zero_o     = rf[DPOU_XIN_ZERO][31:0];
  assign xin_one_o      = rf[DPOU_XIN_ONE][31:0];
  assign yin_zero_o     = rf[DPOU_YIN_ZERO][31:0];
  assign yin_one_o      = rf[DPOU_YIN_ONE][31:0];

endmodule

// [verif/dpou_props.sv]
// checker: flag, write gating and transfer-field relations at the top ports
// assumes one core clock and rst_n_i as seen at the pins
`timescale 1ns/1ns
// ==========================================
// checker
module dpou_props (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        insn_valid_i,
  input wire logic [31:0] insn_i,
  input wire logic [2:0]  cond_select_i,
  input wire logic        x_load_i,
  input wire logic        y_load_i,
  input wire logic        xfer_valid_o,
  input wire logic [15:0] xfer_field_o,
  input wire logic        cond_flag_o,
  input wire logic [39:0] acc_zero_o,
  input wire logic [39:0] acc_one_o,
  input wire logic [31:0] mul_out_zero_o,
  input wire logic [31:0] mul_out_one_o,
  input wire logic [31:0] xin_zero_o,
  input wire logic [31:0] xin_one_o,
  input wire logic [31:0] yin_zero_o,
  input wire logic [31:0] yin_one_o
);
  logic         taken;
  logic         quiet;
  logic [15:0]  bf;
  logic [271:0] regs;
  logic [39:0]  dual_sum;
  assign taken = insn_valid_i && (insn_i[31:26] == 6'h3E);
  assign quiet = !x_load_i && !y_load_i;
  assign bf = insn_i[15:0];
  assign regs = {acc_zero_o, acc_one_o, mul_out_zero_o, mul_out_one_o,
                 xin_zero_o, xin_one_o, yin_zero_o, yin_one_o};
  assign dual_sum = {{8{xin_zero_o[31]}}, xin_zero_o} + {{8{yin_zero_o[31]}}, yin_zero_o};
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  a_xfer_field_pass: assert property (taken |=> xfer_valid_o && xfer_field_o == $past(insn_i[31:16]))
    else $error("transfer field not passed on");
  a_xfer_needs_word: assert property (xfer_valid_o |-> $past(taken))
    else $error("transfer pulse without a parallel word");
  a_foreign_ignored: assert property (insn_valid_i && !taken && quiet |=> $stable(regs) && !xfer_valid_o)
    else $error("non-parallel word changed state");
  a_cond_flag_kept: assert property (taken && bf[15] && bf[9] |=> $stable(cond_flag_o))
    else $error("conditional op changed the flag");
  a_mul_flag_kept: assert property (taken && bf[15:12] == 4'h4 |=> $stable(cond_flag_o))
    else $error("multiply changed the flag");
  a_true_gate: assert property (taken && quiet && bf[15] && bf[9:8] == 2'h2
    && !cond_flag_o |=> $stable(regs))
    else $error("flag-true op wrote with flag clear");
  a_false_gate: assert property (taken && quiet && bf[15] && bf[9:8] == 2'h3
    && cond_flag_o |=> $stable(regs))
    else $error("flag-false op wrote with flag set");
  a_zero_clear_flag: assert property (taken && cond_select_i == 3'h2
    && bf[15:4] == 12'h8D0 |=> cond_flag_o)
    else $error("clear in zero mode left flag low");
  a_logic_carry_clr: assert property (taken && cond_select_i == 3'h0
    && bf[15:14] == 2'h2 && bf[11:8] == 4'h5 |=> !cond_flag_o)
    else $error("logical op in carry mode left flag set");
  a_neg_mode_sign: assert property (taken && cond_select_i == 3'h1
    && bf == 16'hA100 |=> cond_flag_o == acc_zero_o[39])
    else $error("negative mode flag differs from sign");
  a_dual_acc_sum: assert property (taken && quiet && bf[15:12] == 4'h7
    && bf[7:4] == 4'h0 && bf[1:0] == 2'h2 && bf[3:2] != 2'h2
    |=> acc_zero_o == $past(dual_sum))
    else $error("dual add result wrong");
  c_dual: cover property (taken && bf[15:12] == 4'h7);
  c_cond: cover property (taken && bf[15] && bf[9]);
  c_clear: cover property (taken && bf[15:4] == 12'h8D0);
endmodule
bind dpou_top dpou_props chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .insn_valid_i(insn_valid_i), .insn_i(insn_i),
  .cond_select_i(cond_select_i), .x_load_i(x_load_i), .y_load_i(y_load_i),
  .xfer_valid_o(xfer_valid_o), .xfer_field_o(xfer_field_o), .cond_flag_o(cond_flag_o),
  .acc_zero_o(acc_zero_o), .acc_one_o(acc_one_o), .mul_out_zero_o(mul_out_zero_o),
  .mul_out_one_o(mul_out_one_o), .xin_zero_o(xin_zero_o), .xin_one_o(xin_one_o),
  .yin_zero_o(yin_zero_o), .yin_one_o(yin_one_o));

// [verif/dpou_issue_model.sv]
// issue stage model: presents parallel words and transfer loads to the unit
// assumes its tasks are entered 1 ns after a rising clock edge
`timescale 1ns/1ns
// ==========================================
// issue model
module dpou_issue_model (
  input  wire logic  clock_i,
  output logic        valid_o,
  output logic [31:0] insn_o,
  output logic [2:0]  cs_o,
  output logic        x_load_o,
  output logic        x_sel_o,
  output logic [15:0] x_data_o,
  output logic        y_load_o,
  output logic        y_sel_o,
  output logic [15:0] y_data_o
);
  initial begin
    valid_o = 1'b0;
    insn_o = 32'h0;
    cs_o = 3'h2;
    {x_load_o, x_sel_o, x_data_o, y_load_o, y_sel_o, y_data_o} = 36'h0;
  end
  // valid stays up between back-to-back words
  task automatic issue(input logic [31:0] w, input logic [2:0] cs);
    valid_o = 1'b1;
    insn_o = w;
    cs_o = cs;
    @(posedge clock_i);
    #1;
  endtask
  // a released word bus shows no stale value
  task automatic idle();
    valid_o = 1'b0;
    insn_o = ~insn_o;
  endtask
  // x and y loads land in the upper halves of sel 0 registers
  task automatic load(input logic [15:0] xd, input logic [15:0] yd);
    {x_load_o, x_sel_o, x_data_o} = {2'b10, xd};
    {y_load_o, y_sel_o, y_data_o} = {2'b10, yd};
    @(posedge clock_i);
    #1;
    x_load_o = 1'b0;
    y_load_o = 1'b0;
    x_data_o = ~xd;
    y_data_o = ~yd;
  endtask
endmodule

// [verif/test_dsp_parallel_op_unit.sv]
// testbench of the parallel dsp operation unit
// assumes the design package, the issue model and the bound checker
`timescale 1ns/1ns
module test_dsp_parallel_op_unit
  import dpou_pkg::*;
;
  typedef struct {logic [2:0] cs; logic [15:0] b; dpou_reg_type r;
                  dpou_word_type v; logic f;} dpou_row_type;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        insn_valid, x_load, x_sel, y_load, y_sel;
  logic [31:0] insn;
  logic [2:0]  cond_sel;
  logic [15:0] x_data, y_data, xfer_field;
  logic        xfer_valid, cond_flag, illegal;
  logic [39:0] acc_zero, acc_one;
  logic [31:0] mul_out_zero, mul_out_one, xin_zero, xin_one, yin_zero, yin_one;
  logic [39:0] regv [8];
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;
  // x0 = 0003_0000, y0 = 0005_0000; shifts use y0 bits 23:16 as amount 5
  dpou_row_type rows [28] = '{
    '{3'h2, 16'hB105, DPOU_XIN_ONE, 40'h80000, 1'h0},
    '{3'h2, 16'hA100, DPOU_ACC_ZERO, 40'hFFFFFE0000, 1'h0},
    '{3'h2, 16'hA507, DPOU_YIN_ONE, 40'h60000, 1'h0},
    '{3'h2, 16'h9502, DPOU_MUL_OUT_ZERO, 40'h10000, 1'h0},
    '{3'h2, 16'hB503, DPOU_MUL_OUT_ONE, 40'h70000, 1'h0},
    '{3'h2, 16'hD901, DPOU_ACC_ONE, 40'h30000, 1'h0},
    '{3'h2, 16'hF905, DPOU_XIN_ONE, 40'h50000, 1'h0},
    '{3'h2, 16'hC900, DPOU_ACC_ZERO, 40'hFFFFFD0000, 1'h0},
    '{3'h2, 16'h9905, DPOU_XIN_ONE, 40'h40000, 1'h0},
    '{3'h2, 16'h8905, DPOU_XIN_ONE, 40'h20000, 1'h0},
    '{3'h2, 16'h8105, DPOU_XIN_ONE, 40'h600000, 1'h0},
    '{3'h2, 16'h8D05, DPOU_XIN_ONE, 40'h0, 1'h1},
    '{3'h2, 16'h9205, DPOU_XIN_ONE, 40'h600000, 1'h1},
    '{3'h2, 16'hB305, DPOU_XIN_ONE, 40'h600000, 1'h1},
    '{3'h2, 16'hB205, DPOU_XIN_ONE, 40'h80000, 1'h1},
    '{3'h2, 16'h4000, DPOU_MUL_OUT_ZERO, 40'h1E, 1'h1},
    '{3'h2, 16'h7006, DPOU_ACC_ZERO, 40'h80000, 1'h0},
    '{3'h2, 16'hA705, DPOU_XIN_ONE, 40'h60000, 1'h0},
    '{3'h0, 16'hA100, DPOU_ACC_ZERO, 40'hFFFFFE0000, 1'h1},
    '{3'h0, 16'h9502, DPOU_MUL_OUT_ZERO, 40'h10000, 1'h0},
    '{3'h1, 16'hA100, DPOU_ACC_ZERO, 40'hFFFFFE0000, 1'h1},
    '{3'h1, 16'hB105, DPOU_XIN_ONE, 40'h80000, 1'h0},
    '{3'h0, 16'h8105, DPOU_XIN_ONE, 40'h600000, 1'h0},
    '{3'h4, 16'hB101, DPOU_ACC_ONE, 40'h80000, 1'h1},
    '{3'h3, 16'hA101, DPOU_ACC_ONE, 40'hFFFFFE0000, 1'h0},
    '{3'h5, 16'hB101, DPOU_ACC_ONE, 40'h80000, 1'h1},
    '{3'h2, 16'h9D01, DPOU_ACC_ONE, 40'hD, 1'h0},
    '{3'h2, 16'h9206, DPOU_YIN_ZERO, 40'h50000, 1'h0}};
  always #5 clock = ~clock;
  always_comb regv = '{acc_zero, acc_one, {8'h00, mul_out_zero}, {8'h00, mul_out_one},
                       {8'h00, xin_zero}, {8'h00, xin_one}, {8'h00, yin_zero}, {8'h00, yin_one}};
  dpou_issue_model iss (.clock_i(clock), .valid_o(insn_valid), .insn_o(insn), .cs_o(cond_sel),
    .x_load_o(x_load), .x_sel_o(x_sel), .x_data_o(x_data), .y_load_o(y_load), .y_sel_o(y_sel),
    .y_data_o(y_data));
  dpou_top dut (.clock_i(clock), .rst_n_i(rst_n), .insn_valid_i(insn_valid), .insn_i(insn),
    .cond_select_i(cond_sel), .x_load_i(x_load), .x_load_sel_i(x_sel), .x_load_data_i(x_data),
    .y_load_i(y_load), .y_load_sel_i(y_sel), .y_load_data_i(y_data), .xfer_valid_o(xfer_valid),
    .xfer_field_o(xfer_field), .cond_flag_o(cond_flag), .acc_zero_o(acc_zero),
    .acc_one_o(acc_one), .mul_out_zero_o(mul_out_zero), .mul_out_one_o(mul_out_one),
    .xin_zero_o(xin_zero), .xin_one_o(xin_one), .yin_zero_o(yin_zero), .yin_one_o(yin_one),
    .illegal_o(illegal));
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      test_done();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    for (int r = 0; r < 8; r++) check(regv[r], 40'h0);
    check(cond_flag, 1'b0);
    $display("reset test done");
    iss.load(16'h0003, 16'h0005);
    check(regv[DPOU_XIN_ZERO], 40'h30000);
    check(regv[DPOU_YIN_ZERO], 40'h50000);
    foreach (rows[i]) begin
      iss.issue({8'hF8, 8'(i), rows[i].b}, rows[i].cs);
      check(regv[rows[i].r], rows[i].v);
      check(illegal, 1'b0);
      check(cond_flag, rows[i].f);
      check(xfer_valid, 1'b1);
      check(xfer_field, {8'hF8, 8'(i)});
      $display("row %0d test done", i);
    end
    check(mul_out_one, 32'h1E);
    iss.idle();
    @(posedge clock);
    #1;
    iss.issue(32'h0000_B105, 3'h2);
    check(regv[DPOU_XIN_ONE], 40'h600000);
    check(xfer_valid, 1'b0);
    iss.issue(32'hF800_8000, 3'h2);
    check(illegal, 1'b1);
    check(xfer_valid, 1'b1);
    iss.idle();
    $display("foreign and illegal word test done");
    test_done();
  end
endmodule
